// file: design/spgp_defines.vh
// shared constants for the shared pin gpio port: offsets, fields, resets
`ifndef SPGP_DEFINES_VH
`define SPGP_DEFINES_VH
// ****************************************
// register word offsets (byte address = 4 * index)
// ****************************************
`define SPGP_IDX_DATA 4'h0
`define SPGP_IDX_DIR 4'h1
`define SPGP_IDX_ANALOG_DIS 4'h2
`define SPGP_IDX_LCD_SEL 4'h3
`define SPGP_IDX_CTRL 4'h4
`define SPGP_IDX_RMW_DATA 4'h5
`define SPGP_IDX_PIN 4'h6
`define SPGP_IDX_LAST 4'h6
// ****************************************
// control register fields
// ****************************************
`define SPGP_CTRL_LCD_PORT_INPUT_CONTROL_BIT 0
`define SPGP_CTRL_SPL_BIT 1
`define SPGP_CTRL_STBY_BIT 2
// ****************************************
// reset values
// ****************************************
`define SPGP_RST_DATA 8'h00
`define SPGP_RST_DIR 8'h00
`define SPGP_RST_ANALOG_DIS 8'h00
`define SPGP_RST_LCD_SEL 8'h00
`define SPGP_RST_CTRL 2'h0
// ****************************************
// bus timing: read data one cycle after request
// ****************************************
`define SPGP_READ_LATENCY 1
`endif

// file: design/spgp_pin_cell.v
// per pin drive and input gating for the shared pins
`timescale 1ns/10ps
module spgp_pin_cell #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] dir_in,
  input wire [WIDTH-1:0] latch_in,
  input wire [WIDTH-1:0] periph_oe_in,
  input wire [WIDTH-1:0] periph_do_in,
  input wire [WIDTH-1:0] lcd_sel_in,
  input wire [WIDTH-1:0] lcd_seg_in,
  input wire [WIDTH-1:0] analog_cap_in,
  input wire [WIDTH-1:0] analog_dis_in,
  input wire [WIDTH-1:0] pin_level_in,
  input wire lcd_port_input_control_in,
  input wire hiz_in,
  output reg [WIDTH-1:0] drive_oe_out,
  output reg [WIDTH-1:0] drive_val_out,
  output reg [WIDTH-1:0] dig_in_out
);
  integer i;
  always @* begin
    drive_oe_out = {WIDTH{1'b0}};
    drive_val_out = {WIDTH{1'b0}};
    dig_in_out = {WIDTH{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (hiz_in) begin
        drive_oe_out[i] = 1'b0;
        drive_val_out[i] = 1'b0;
      end else if (lcd_sel_in[i] && lcd_port_input_control_in && !dir_in[i]) begin
        drive_oe_out[i] = 1'b1;
        drive_val_out[i] = lcd_seg_in[i];
      end else if (periph_oe_in[i]) begin
        drive_oe_out[i] = 1'b1;
        drive_val_out[i] = periph_do_in[i];
      end else if (dir_in[i]) begin
        drive_oe_out[i] = 1'b1;
        drive_val_out[i] = latch_in[i];
      end
      // analog pins keep digital input off until the disable bit is set
      if (hiz_in) begin
        dig_in_out[i] = 1'b0;
      end else if (analog_cap_in[i] && !analog_dis_in[i]) begin
        dig_in_out[i] = 1'b0;
      end else if (lcd_sel_in[i]) begin
        dig_in_out[i] = 1'b0;
      end else begin
        dig_in_out[i] = pin_level_in[i];
      end
    end
  end
endmodule

// file: design/spgp_pin_sync.v
// three flop synchroniser with agreement filter for the port pins
`timescale 1ns/10ps
module spgp_pin_sync #(
  parameter WIDTH = 8
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  integer i;
  // only s2 and s3 are compared; s1 feeds nothing but s2
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      level_out <= {WIDTH{1'b0}};
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_out[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule

// file: design/spgp_port.v
// top of the shared pin gpio port with avalon-mm register slave
// ****************************************
// Function
// - direction bit one makes pin output
// - output pin shows latch continuously
// - data write updates latch and pin
// - output pin read returns latch
// - direction bit zero makes pin input
// - input pin write updates latch only
// - input read gives pin; rmw gives latch
// - peripheral drives pin; reads see pin
// - peripheral input: pin read, rmw latch
// - port0 lcd pins: clear select, set lcd_port_input_control
// - port6 lcd select bits same sequence
// - segment output: dir0, select1, pictl1
// - reset clears all direction bits
// - analog disable resets to zero
// - standby with spl forces hiz, input low
// - standby without spl keeps pin state
// - bit n maps to pin n
// ****************************************
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "spgp_defines.vh"
module spgp_port #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] ANALOG_CAPABLE = 8'hff
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe_out,
  input wire [WIDTH-1:0] periph_oe_in,
  input wire [WIDTH-1:0] periph_do_in,
  input wire [WIDTH-1:0] lcd_seg_in,
  input wire standby_mode_in,
  output reg [WIDTH-1:0] periph_din_out
);
  // ****************************************
  // registers
  // ****************************************
  // bus states, one-hot
  localparam [2:0] BUS_IDLE = 3'b001;
  localparam [2:0] BUS_READ = 3'b010;
  localparam [2:0] BUS_WRITE = 3'b100;
  // bit positions of the one-hot register select
  localparam SEL_DATA = 0;
  localparam SEL_DIR = 1;
  localparam SEL_ANALOG_DIS = 2;
  localparam SEL_LCD_SEL = 3;
  localparam SEL_CTRL = 4;
  localparam SEL_RMW_DATA = 5;
  localparam SEL_PIN = 6;
  reg [WIDTH-1:0] data_latch_ff;
  reg [WIDTH-1:0] direction_ff;
  reg [WIDTH-1:0] analog_dis_ff;
  reg [WIDTH-1:0] lcd_sel_ff;
  reg [1:0] ctrl_ff;
  reg [2:0] bus_state_ff;
  reg [WIDTH-1:0] nxt_data_latch;
  reg [WIDTH-1:0] nxt_direction;
  reg [WIDTH-1:0] nxt_analog_dis;
  reg [WIDTH-1:0] nxt_lcd_sel;
  reg [1:0] nxt_ctrl;
  reg [2:0] nxt_bus_state;
  reg [31:0] nxt_readdata;
  wire [6:0] reg_sel;
  wire [WIDTH-1:0] pin_sync;
  wire [WIDTH-1:0] drive_oe;
  wire [WIDTH-1:0] drive_val;
  wire [WIDTH-1:0] dig_in;
  wire lcd_port_input_control;
  wire hiz;
  wire wr_hit;
  wire rd_start;
  assign lcd_port_input_control = ctrl_ff[`SPGP_CTRL_LCD_PORT_INPUT_CONTROL_BIT];
  // standby only isolates when the pin state bit is set
  assign hiz = standby_mode_in & ctrl_ff[`SPGP_CTRL_SPL_BIT];
  // a write lands only in its answer cycle, where the master sees waitrequest low
  assign wr_hit = avs_write_in & avs_byteenable_in[0] & (bus_state_ff == BUS_WRITE);
  assign rd_start = avs_read_in & (bus_state_ff == BUS_IDLE);

  // ****************************************
  // helpers
  // ****************************************
  function [31:0] spgp_zext;
    input [WIDTH-1:0] v;
    begin
      spgp_zext = {{(32-WIDTH){1'b0}}, v};
    end
  endfunction

  // one-hot register select, shared by the write and read paths
  function [6:0] spgp_decode;
    input [3:0] idx;
    begin
      spgp_decode = 7'h00;
      case (idx)
        `SPGP_IDX_DATA: begin
          spgp_decode = 7'h01;
        end
        `SPGP_IDX_DIR: begin
          spgp_decode = 7'h02;
        end
        `SPGP_IDX_ANALOG_DIS: begin
          spgp_decode = 7'h04;
        end
        `SPGP_IDX_LCD_SEL: begin
          spgp_decode = 7'h08;
        end
        `SPGP_IDX_CTRL: begin
          spgp_decode = 7'h10;
        end
        `SPGP_IDX_RMW_DATA: begin
          spgp_decode = 7'h20;
        end
        `SPGP_IDX_PIN: begin
          spgp_decode = 7'h40;
        end
        default: begin
          spgp_decode = 7'h00;
        end
      endcase
    end
  endfunction

  // ****************************************
  // pin path
  // ****************************************
  spgp_pin_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(pin_in),
    .level_out(pin_sync)
  );

  spgp_pin_cell #(
    .WIDTH(WIDTH)
  ) u_cell (
    .dir_in(direction_ff),
    .latch_in(data_latch_ff),
    .periph_oe_in(periph_oe_in),
    .periph_do_in(periph_do_in),
    .lcd_sel_in(lcd_sel_ff),
    .lcd_seg_in(lcd_seg_in),
    .analog_cap_in(ANALOG_CAPABLE),
    .analog_dis_in(analog_dis_ff),
    .pin_level_in(pin_sync),
    .lcd_port_input_control_in(lcd_port_input_control),
    .hiz_in(hiz),
    .drive_oe_out(drive_oe),
    .drive_val_out(drive_val),
    .dig_in_out(dig_in)
  );

  // ****************************************
  // register writes
  // ****************************************
  assign reg_sel = spgp_decode(avs_address_in);
  always @* begin
    nxt_data_latch = data_latch_ff;
    nxt_direction = direction_ff;
    nxt_analog_dis = analog_dis_ff;
    nxt_lcd_sel = lcd_sel_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_hit) begin
      // both data views write the same latch
      if (reg_sel[SEL_DATA] | reg_sel[SEL_RMW_DATA]) begin
        nxt_data_latch = avs_writedata_in[WIDTH-1:0];
      end
      if (reg_sel[SEL_DIR]) begin
        nxt_direction = avs_writedata_in[WIDTH-1:0];
      end
      if (reg_sel[SEL_ANALOG_DIS]) begin
        nxt_analog_dis = avs_writedata_in[WIDTH-1:0];
      end
      if (reg_sel[SEL_LCD_SEL]) begin
        nxt_lcd_sel = avs_writedata_in[WIDTH-1:0];
      end
      // the standby flag is read only, so only two bits are kept
      if (reg_sel[SEL_CTRL]) begin
        nxt_ctrl = avs_writedata_in[1:0];
      end
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always @* begin
    // unmapped indices fall through and read as zero
    nxt_readdata = 32'h00000000;
    if (reg_sel[SEL_DATA]) begin
      // output pins read the latch, others the synchronised and gated dig_in (zero on lcd pins and analog pins not disabled)
      nxt_readdata = spgp_zext((direction_ff & data_latch_ff) |
        (~direction_ff & dig_in));
    end
    if (reg_sel[SEL_RMW_DATA]) begin
      nxt_readdata = spgp_zext(data_latch_ff);
    end
    if (reg_sel[SEL_DIR]) begin
      nxt_readdata = spgp_zext(direction_ff);
    end
    if (reg_sel[SEL_ANALOG_DIS]) begin
      nxt_readdata = spgp_zext(analog_dis_ff);
    end
    if (reg_sel[SEL_LCD_SEL]) begin
      nxt_readdata = spgp_zext(lcd_sel_ff);
    end
    // the standby flag sits above the two writable control bits
    if (reg_sel[SEL_CTRL]) begin
      nxt_readdata = {29'h0000000, standby_mode_in, ctrl_ff};
    end
    if (reg_sel[SEL_PIN]) begin
      nxt_readdata = spgp_zext(dig_in);
    end
  end

  // ****************************************
  // bus handshake
  // ****************************************
  // every access is two cycles: seen in idle, finished in the answer cycle,
  // so writes end on waitrequest low exactly as reads do
  // read and write are never high together; read would win if they were
  always @* begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      BUS_IDLE: begin
        if (avs_read_in) begin
          nxt_bus_state = BUS_READ;
        end else if (avs_write_in) begin
          nxt_bus_state = BUS_WRITE;
        end
      end
      BUS_READ: begin
        nxt_bus_state = BUS_IDLE;
      end
      BUS_WRITE: begin
        nxt_bus_state = BUS_IDLE;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  // ****************************************
  // sequential
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      data_latch_ff <= `SPGP_RST_DATA;
      direction_ff <= `SPGP_RST_DIR;
      analog_dis_ff <= `SPGP_RST_ANALOG_DIS;
      lcd_sel_ff <= `SPGP_RST_LCD_SEL;
      ctrl_ff <= `SPGP_RST_CTRL;
      bus_state_ff <= BUS_IDLE;
    end else begin
      data_latch_ff <= nxt_data_latch;
      direction_ff <= nxt_direction;
      analog_dis_ff <= nxt_analog_dis;
      lcd_sel_ff <= nxt_lcd_sel;
      ctrl_ff <= nxt_ctrl;
      bus_state_ff <= nxt_bus_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output leaves from a flop so the pins never see decode glitches
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h00000000;
      avs_waitrequest_out <= 1'b1;
      pin_out <= {WIDTH{1'b0}};
      pin_oe_out <= {WIDTH{1'b0}};
      periph_din_out <= {WIDTH{1'b0}};
    end else begin
      if (rd_start) begin
        avs_readdata_out <= nxt_readdata;
      end
      // waitrequest is low for the single answer cycle only
      avs_waitrequest_out <= (nxt_bus_state == BUS_IDLE);
      // standby without spl just holds the normal drive
      pin_out <= drive_val;
      pin_oe_out <= drive_oe;
      periph_din_out <= dig_in;
    end
  end
endmodule

// file: verif/spgp_pin_model.sv
// external pin model: resolves the shared pin level
`timescale 1ns/10ps
module spgp_pin_model (
  input wire [7:0] drv_in,
  input wire [7:0] oe_in,
  input wire [7:0] ext_in,
  input wire ext_en_in,
  output wire [7:0] level_out
);
  // an undriven line shows ext_in when ext_en_in is set, else the inverse of the drive, never a held value
  assign level_out = (oe_in & drv_in) | (~oe_in & (ext_en_in ? ext_in : ~drv_in));
endmodule

// file: verif/spgp_port_checker.sv
// port-level assertions for the shared pin gpio port
`timescale 1ns/10ps
module spgp_port_checker #(
  parameter WIDTH = 8
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [WIDTH-1:0] pin_out,
  input wire [WIDTH-1:0] pin_oe_out,
  input wire [WIDTH-1:0] periph_oe_in,
  input wire standby_mode_in,
  input wire [WIDTH-1:0] periph_din_out
);
  // ****
  // bus and pin relations
  // ****
  default clocking cb @(posedge clk_sys_in); endclocking
  sequence s_rd_req;
    avs_read_in && avs_waitrequest_out;
  endsequence
  sequence s_rd_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  sequence s_wr_req;
    avs_write_in && avs_waitrequest_out;
  endsequence
  a_reset_quiet: assert property (sys_rst_in |=> pin_oe_out == 0 && pin_out == 0)
    else $error("pins driven after reset");
  a_reset_input: assert property (sys_rst_in |=> avs_waitrequest_out && periph_din_out == 0)
    else $error("input path or bus active after reset");
  a_read_answer: assert property (disable iff (sys_rst_in) s_rd_req |=> s_rd_ans)
    else $error("read answer not one cycle later");
  a_wait_cause: assert property (disable iff (sys_rst_in)
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
    else $error("waitrequest dropped without request");
  a_write_answer: assert property (disable iff (sys_rst_in) s_wr_req |=> s_rd_ans)
    else $error("write answer not one cycle later");
  a_upper_zero: assert property (disable iff (sys_rst_in)
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 0)
    else $error("upper read data not zero");
  a_data_stands: assert property (disable iff (sys_rst_in)
    !$past(avs_read_in) |-> $stable(avs_readdata_out))
    else $error("read data moved without read");
  // standby can be filtered by a flop, so two quiet cycles are required
  a_periph_drive: assert property (disable iff (sys_rst_in)
    !$past(sys_rst_in) && !$past(standby_mode_in) && !$past(standby_mode_in, 2)
    |-> ($past(periph_oe_in) & ~pin_oe_out) == 0)
    else $error("peripheral enable not driving pin");
endmodule

// file: verif/tb_top.sv
// self-checking bench for the shared pin gpio port
`timescale 1ns/10ps
`include "spgp_defines.vh"
module tb_top;
  logic clk_sys_in, sys_rst_in, rd, wr, stby, een;
  logic [3:0] adr, be;
  logic [31:0] wd, v;
  logic [7:0] ext, poe, pdo, lcd_segment_select, lv;
  wire [31:0] rdo;
  wire wreq;
  wire [7:0] lvl, p_out, p_oe, din;
  int n_fail, n_compared, i;
  // rows: direction, latch, external level
  logic [7:0] rows [4][3] = '{'{8'hff, 8'ha5, 8'h00}, '{8'h00, 8'ha5, 8'h3c},
    '{8'h0f, 8'hc3, 8'h5a}, '{8'h80, 8'h01, 8'h7f}};
  spgp_port uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq), .pin_in(lvl), .pin_out(p_out),
    .pin_oe_out(p_oe), .periph_oe_in(poe), .periph_do_in(pdo), .lcd_seg_in(lcd_segment_select),
    .standby_mode_in(stby), .periph_din_out(din));
  spgp_pin_model u_pins (.drv_in(p_out), .oe_in(p_oe), .ext_in(ext), .ext_en_in(een),
    .level_out(lvl));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // request held until waitrequest is seen low; only the watchdog ends a hung wait
  task automatic bus_xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
    input logic [3:0] b);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= {24'h0, d};
    be <= b;
    wr <= w;
    rd <= ~w;
    @(posedge clk_sys_in);
    while (wreq !== 1'b0) begin
      @(posedge clk_sys_in);
    end
    v = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] b = 4'h1);
    bus_xfer(1'b1, a, d, b);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    bus_xfer(1'b0, a, 8'h00, 4'hf);
    check(v, {24'h0, exp});
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_sys_in);
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #(25 * 5000);
    n_fail++;
    summarize;
  end
  initial begin
    sys_rst_in <= 1'b1;
    {rd, wr, stby, adr, be, wd, poe, pdo, lcd_segment_select} <= '0;
    ext <= 8'hff;
    een <= 1'b1;
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    settle;
    rdchk(`SPGP_IDX_DIR, 8'h00);
    rdchk(`SPGP_IDX_RMW_DATA, 8'h00);
    rdchk(`SPGP_IDX_ANALOG_DIS, 8'h00);
    rdchk(`SPGP_IDX_PIN, 8'h00);
    check(din, 0);
    bus_wr(`SPGP_IDX_ANALOG_DIS, 8'hff);
    bus_wr(`SPGP_IDX_CTRL, 8'h01);
    for (i = 0; i < 4; i++) begin
      bus_wr(`SPGP_IDX_DATA, rows[i][1]);
      bus_wr(`SPGP_IDX_DIR, rows[i][0]);
      ext <= rows[i][2];
      settle;
      lv = (rows[i][1] & rows[i][0]) | (rows[i][2] & ~rows[i][0]);
      check(p_oe, rows[i][0]);
      check(p_out & rows[i][0], rows[i][1] & rows[i][0]);
      rdchk(`SPGP_IDX_DATA, lv);
      rdchk(`SPGP_IDX_RMW_DATA, rows[i][1]);
      check(din, lv);
    end
    bus_wr(`SPGP_IDX_DIR, 8'h00);
    poe <= 8'h0f;
    pdo <= 8'h05;
    ext <= 8'ha0;
    settle;
    check(p_oe, 8'h0f);
    rdchk(`SPGP_IDX_DATA, 8'ha5);
    rdchk(`SPGP_IDX_RMW_DATA, 8'h01);
    poe <= 8'h00;
    bus_wr(`SPGP_IDX_LCD_SEL, 8'h03);
    lcd_segment_select <= 8'h02;
    settle;
    check(p_oe, 8'h03);
    check(p_out & 8'h03, 8'h02);
    check(din, 8'ha0);
    bus_wr(`SPGP_IDX_LCD_SEL, 8'h00);
    bus_wr(`SPGP_IDX_DIR, 8'hff);
    bus_wr(`SPGP_IDX_DATA, 8'h5a);
    bus_wr(`SPGP_IDX_DATA, 8'hff, 4'h0);
    rdchk(`SPGP_IDX_RMW_DATA, 8'h5a);
    rdchk(4'h7, 8'h00);
    bus_wr(`SPGP_IDX_CTRL, 8'h03);
    stby <= 1'b1;
    een <= 1'b0;
    settle;
    check(p_oe, 8'h00);
    check(din, 8'h00);
    rdchk(`SPGP_IDX_CTRL, 8'h07);
    stby <= 1'b0;
    een <= 1'b1;
    bus_wr(`SPGP_IDX_CTRL, 8'h01);
    stby <= 1'b1;
    settle;
    check(p_oe, 8'hff);
    check(p_out, 8'h5a);
    stby <= 1'b0;
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rdchk(`SPGP_IDX_DIR, 8'h00);
    rdchk(`SPGP_IDX_RMW_DATA, 8'h00);
    check(p_oe, 8'h00);
    summarize;
  end
endmodule
bind spgp_port spgp_port_checker #(.WIDTH(WIDTH)) u_chk (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out), .periph_oe_in(periph_oe_in),
  .standby_mode_in(standby_mode_in), .periph_din_out(periph_din_out));
